/* common/bdm_pkg.sv */
// constants and types for the banked data memory addressing block
package bdm_pkg;

  // data memory geometry
  localparam int          BDM_DATA_W        = 8;
  localparam int          BDM_PC_W          = 12;
  localparam int          BDM_GP_DEPTH      = 160;

  // special function register map, bank 0
  localparam logic [7:0]  BDM_ADDR_SFR_BASE = 8'h00;
  localparam logic [7:0]  BDM_ADDR_IND0     = 8'h00;
  localparam logic [7:0]  BDM_ADDR_PTR0     = 8'h01;
  localparam logic [7:0]  BDM_ADDR_IND1     = 8'h02;
  localparam logic [7:0]  BDM_ADDR_PTR1     = 8'h03;
  localparam logic [7:0]  BDM_ADDR_BANK     = 8'h04;
  localparam logic [7:0]  BDM_ADDR_ACC      = 8'h05;
  localparam logic [7:0]  BDM_ADDR_PCL      = 8'h06;
  localparam logic [7:0]  BDM_ADDR_EXT_LO   = 8'h07;
  localparam logic [7:0]  BDM_ADDR_EXT_HI   = 8'h1F;
  localparam logic [7:0]  BDM_ADDR_HOLE0    = 8'h0C;
  localparam logic [7:0]  BDM_ADDR_HOLE1_LO = 8'h1A;
  localparam logic [7:0]  BDM_ADDR_HOLE1_HI = 8'h1D;
  localparam logic [7:0]  BDM_ADDR_GP_BASE  = 8'h60;
  localparam logic [7:0]  BDM_ADDR_GP_TOP   = 8'hFF;

  // bank 1 holds a single register
  localparam logic [7:0]  BDM_ADDR_EECTRL   = 8'h40;

  // bank select values and field
  localparam logic [7:0]  BDM_BANK_ZERO     = 8'h00;
  localparam logic [7:0]  BDM_BANK_ONE      = 8'h01;
  localparam int          BDM_BANK_BIT      = 0;

  // reset values
  localparam logic [7:0]  BDM_RST_PTR       = 8'h00;
  localparam logic [7:0]  BDM_RST_BANK      = BDM_BANK_ZERO;
  localparam logic [7:0]  BDM_RST_ACC       = 8'h00;
  localparam logic [7:0]  BDM_RST_EECTRL    = 8'h00;
  localparam logic [11:0] BDM_RST_PC        = 12'h000;
  localparam logic [7:0]  BDM_READ_ZERO     = 8'h00;

  // what a resolved address lands on
  typedef enum logic [3:0] {
    BDM_RG_NULL,
    BDM_RG_PTR0,
    BDM_RG_PTR1,
    BDM_RG_BANK,
    BDM_RG_ACC,
    BDM_RG_PCL,
    BDM_RG_EXT,
    BDM_RG_GP,
    BDM_RG_EECTRL
  } bdm_region_t;

endpackage

/* common/bdm_map_if.sv */
// address map lookup between the core logic and the region decoder
`timescale 1ns/1ps
`default_nettype none
interface bdm_map_if;
  import bdm_pkg::*;
  logic [7:0]  eff_addr;
  logic        bank;
  bdm_region_t region;

  modport requester (output eff_addr, output bank, input region);
  modport decoder   (input eff_addr, input bank, output region);
endinterface
`default_nettype wire

/* design/bdm_region_decode.sv */
// region decoder for the banked data memory map
`timescale 1ns/1ps
`default_nettype none
module bdm_region_decode
  import bdm_pkg::*;
(
  bdm_map_if.decoder map
);

  logic [7:0] a;
  logic       hole;

  assign a = map.eff_addr;
  // reserved holes inside the peripheral register span
  assign hole = (a == BDM_ADDR_HOLE0) || (a >= BDM_ADDR_HOLE1_LO && a <= BDM_ADDR_HOLE1_HI);

  // map an effective address plus bank onto a target
  always_comb begin
    map.region = BDM_RG_NULL;
    if (map.bank && a == BDM_ADDR_EECTRL) begin
      map.region = BDM_RG_EECTRL;
    end else if (map.bank && a >= BDM_ADDR_GP_BASE) begin
      map.region = BDM_RG_NULL; // bank 1 has no general memory
    end else if (a >= BDM_ADDR_GP_BASE) begin
      map.region = BDM_RG_GP;
    end else begin
      // registers below general memory ignore the bank
      unique case (a)
        BDM_ADDR_IND0: map.region = BDM_RG_NULL;
        BDM_ADDR_IND1: map.region = BDM_RG_NULL;
        BDM_ADDR_PTR0: map.region = BDM_RG_PTR0;
        BDM_ADDR_PTR1: map.region = BDM_RG_PTR1;
        BDM_ADDR_BANK: map.region = BDM_RG_BANK;
        BDM_ADDR_ACC:  map.region = BDM_RG_ACC;
        BDM_ADDR_PCL:  map.region = BDM_RG_PCL;
        default: begin
          if (a >= BDM_ADDR_EXT_LO && a <= BDM_ADDR_EXT_HI && !hole) begin
            map.region = BDM_RG_EXT;
          end else begin
            map.region = BDM_RG_NULL;
          end
        end
      endcase
    end
  end

endmodule
`default_nettype wire

/* design/bdm_core.sv */
// data memory address steering, pointers, bank, accumulator and program counter low byte
// Summary of operation
// - special function registers start at data address 00H
// - unused locations below general memory read back as 00H
// - indirect port access goes to the location held in its pointer
// - port zero reaches bank 0 only; port one reaches both banks
// - indirect port reached through indirection reads 00H, writes do nothing
// - both pointers are real 8-bit read/write registers
// - bank value 00 selects bank 0, 01 selects bank 1
// - bank 1 holds only the EEPROM control register at 40H via port one
// - port zero accesses go to bank 0 whatever the bank value
// - resets clear the bank except watchdog time-out in power-down
// - special function registers stay reachable in either bank
// - direct addressing always hits bank 0
// - ALU results land in the accumulator; memory writes come from it or from the alu result
// - writing the counter low byte jumps within the current page
// - a counter low byte write inserts one dummy instruction cycle
// - a bank spans addresses 00H to FFH
`timescale 1ns/1ps
`default_nettype none
module bdm_core
  import bdm_pkg::*;
#(
  parameter int GP_DEPTH = BDM_GP_DEPTH,
  parameter int PC_W     = BDM_PC_W
) (
  input  wire logic              clk_in,
  input  wire logic              rst_n_in,
  // soft resets from the system controller
  input  wire logic              sys_reset_in,
  input  wire logic              wdt_pd_reset_in,
  // data memory access from the execute stage
  input  wire logic              mem_req_in,
  input  wire logic              mem_write_in,
  input  wire logic [7:0]        mem_addr_in,
  input  wire logic              mem_wsrc_alu_in,
  output logic [7:0]             mem_rdata_out,
  output logic                   mem_rvalid_out,
  // alu result path
  input  wire logic              alu_load_acc_in,
  input  wire logic [7:0]        alu_result_in,
  output logic [7:0]             accumulator_out,
  // program counter
  input  wire logic              pc_step_in,
  output logic [PC_W-1:0]        pc_out,
  output logic                   dummy_cycle_out,
  // peripheral registers outside this block
  output logic                   ext_sfr_rd_out,
  output logic                   ext_sfr_wr_out,
  output logic [7:0]             ext_sfr_addr_out,
  output logic [7:0]             ext_sfr_wdata_out,
  input  wire logic [7:0]        ext_sfr_rdata_in,
  // eeprom control register contents and write strobe, and the bank select value
  output logic [7:0]             eeprom_control_register_out,
  output logic                   eeprom_control_wr_out,
  output logic [7:0]             bank_select_out
);

  // architectural registers
  logic [7:0]      pointer_zero_q;
  logic [7:0]      pointer_one_q;
  logic [7:0]      bank_select_q;
  logic [7:0]      accumulator_q;
  logic [7:0]      eectrl_q;
  logic [PC_W-1:0] pc_q;
  logic            dummy_q;
  logic [7:0]      rdata_q;
  logic            rvalid_q;
  logic [7:0]      gp_mem [0:GP_DEPTH-1];

  // resolved access
  logic            ind_zero;
  logic            ind_one;
  logic [7:0]      eff_addr;
  logic            eff_bank;
  logic [7:0]      wdata;
  logic            wr_en;
  logic            rd_en;
  logic [7:0]      gp_index;
  logic [7:0]      read_mux;
  bdm_region_t     region;

  bdm_map_if map ();

  // pick the pointer when an indirect port is named directly
  assign ind_zero = (mem_addr_in == BDM_ADDR_IND0);
  assign ind_one  = (mem_addr_in == BDM_ADDR_IND1);

  always_comb begin
    if (ind_zero) begin
      eff_addr = pointer_zero_q;
      eff_bank = 1'b0;
    end else if (ind_one) begin
      eff_addr = pointer_one_q;
      eff_bank = bank_select_q[BDM_BANK_BIT];
    end else begin
      eff_addr = mem_addr_in;
      eff_bank = 1'b0;
    end
  end

  assign map.eff_addr = eff_addr;
  assign map.bank     = eff_bank;
  assign region       = map.region;

  // address classification lives in its own module
  bdm_region_decode u_decode (
    .map (map)
  );

  // writes carry the accumulator or a fresh alu result, never a memory value
  assign wdata = mem_wsrc_alu_in ? alu_result_in : accumulator_q;
  assign wr_en = mem_req_in && mem_write_in;
  assign rd_en = mem_req_in && !mem_write_in;

  // general memory index, only meaningful inside the general region
  assign gp_index = eff_addr - BDM_ADDR_GP_BASE;

  // peripheral register strobes are combinational handshakes
  assign ext_sfr_rd_out    = rd_en && (region == BDM_RG_EXT);
  assign ext_sfr_wr_out    = wr_en && (region == BDM_RG_EXT);
  assign ext_sfr_addr_out  = eff_addr;
  assign ext_sfr_wdata_out = wdata;

  // pointer zero
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pointer_zero_q <= BDM_RST_PTR;
    end else if (wr_en && region == BDM_RG_PTR0) begin
      pointer_zero_q <= wdata;
    end
  end

  // pointer one
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pointer_one_q <= BDM_RST_PTR;
    end else if (wr_en && region == BDM_RG_PTR1) begin
      pointer_one_q <= wdata;
    end
  end

  // bank select survives only the watchdog wake from power-down
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bank_select_q <= BDM_RST_BANK;
    end else if (sys_reset_in) begin
      bank_select_q <= BDM_RST_BANK;
    end else if (wdt_pd_reset_in) begin
      bank_select_q <= bank_select_q;
    end else if (wr_en && region == BDM_RG_BANK) begin
      bank_select_q <= wdata;
    end
  end

  // accumulator: alu load wins over a bus write in the same cycle
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      accumulator_q <= BDM_RST_ACC;
    end else if (sys_reset_in) begin
      accumulator_q <= BDM_RST_ACC;
    end else if (alu_load_acc_in) begin
      accumulator_q <= alu_result_in;
    end else if (wr_en && region == BDM_RG_ACC) begin
      accumulator_q <= wdata;
    end
  end

  // eeprom control register in bank 1
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      eectrl_q <= BDM_RST_EECTRL;
    end else if (sys_reset_in) begin
      eectrl_q <= BDM_RST_EECTRL;
    end else if (wr_en && region == BDM_RG_EECTRL) begin
      eectrl_q <= wdata;
    end
  end

  assign eeprom_control_wr_out = wr_en && (region == BDM_RG_EECTRL);

  // program counter; a low byte write keeps the page bits
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pc_q <= PC_W'(BDM_RST_PC);
    end else if (sys_reset_in) begin
      pc_q <= PC_W'(BDM_RST_PC);
    end else if (wr_en && region == BDM_RG_PCL) begin
      pc_q <= {pc_q[PC_W-1:8], wdata};
    end else if (pc_step_in && !dummy_q) begin
      // stepping stays in the fetch unit's hands except during the dummy cycle
      pc_q <= pc_q + {{(PC_W-1){1'b0}}, 1'b1};
    end
  end

  // one dummy cycle after a jump through the low byte
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dummy_q <= 1'b0;
    end else if (sys_reset_in) begin
      dummy_q <= 1'b0;
    end else begin
      dummy_q <= wr_en && (region == BDM_RG_PCL);
    end
  end

  // general purpose storage, no reset as in any ram
  always_ff @(posedge clk_in) begin
    if (wr_en && region == BDM_RG_GP) begin
      gp_mem[gp_index] <= wdata;
    end
  end

  // read data source for the current access
  always_comb begin
    unique case (region)
      BDM_RG_NULL:   read_mux = BDM_READ_ZERO;
      BDM_RG_PTR0:   read_mux = pointer_zero_q;
      BDM_RG_PTR1:   read_mux = pointer_one_q;
      BDM_RG_BANK:   read_mux = bank_select_q;
      BDM_RG_ACC:    read_mux = accumulator_q;
      BDM_RG_PCL:    read_mux = pc_q[7:0];
      BDM_RG_EXT:    read_mux = ext_sfr_rdata_in;
      BDM_RG_GP:     read_mux = gp_mem[gp_index];
      BDM_RG_EECTRL: read_mux = eectrl_q;
      default:       read_mux = BDM_READ_ZERO;
    endcase
  end

  // read data registered one cycle after the request
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_q  <= BDM_READ_ZERO;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= rd_en;
      if (rd_en) begin
        rdata_q <= read_mux;
      end
    end
  end

  // outputs
  assign mem_rdata_out               = rdata_q;
  assign mem_rvalid_out              = rvalid_q;
  assign accumulator_out             = accumulator_q;
  assign pc_out                      = pc_q;
  assign dummy_cycle_out             = dummy_q;
  assign eeprom_control_register_out = eectrl_q;
  assign bank_select_out             = bank_select_q;

endmodule
`default_nettype wire

/* test/bdm_core_monitor.sv */
// port assertions for the data memory steering block
`timescale 1ns/1ps
`default_nettype none
module bdm_core_monitor #(parameter int PC_W = 12) (
  input wire logic            clk_in,
  input wire logic            rst_n_in,
  input wire logic            sys_reset_in,
  input wire logic            wdt_pd_reset_in,
  input wire logic            mem_req_in,
  input wire logic            mem_write_in,
  input wire logic [7:0]      mem_addr_in,
  input wire logic [7:0]      mem_rdata_out,
  input wire logic            mem_rvalid_out,
  input wire logic            alu_load_acc_in,
  input wire logic [7:0]      alu_result_in,
  input wire logic [7:0]      accumulator_out,
  input wire logic [PC_W-1:0] pc_out,
  input wire logic            dummy_cycle_out,
  input wire logic            ext_sfr_rd_out,
  input wire logic [7:0]      bank_select_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  logic rd;
  logic wr;
  logic hole;
  logic program_counter_low;
  // request kinds and the unused address ranges
  assign rd   = mem_req_in & ~mem_write_in;
  assign wr   = mem_req_in & mem_write_in;
  assign program_counter_low  = wr && mem_addr_in == 8'h06 && !sys_reset_in;
  assign hole = mem_addr_in == 8'h0C || (mem_addr_in >= 8'h1A && mem_addr_in <= 8'h1D)
                || (mem_addr_in >= 8'h20 && mem_addr_in < 8'h60);
  a_read_one_cycle: assert property (rd |=> mem_rvalid_out) else $error("read answer missing");
  a_hole_reads_zero: assert property (rd && hole |=> mem_rdata_out == 8'h00) else $error("hole not zero");
  a_pcl_dummy_pulse: assert property (program_counter_low |=> dummy_cycle_out) else $error("no dummy cycle");
  a_pcl_page_kept: assert property (program_counter_low |=> $stable(pc_out[PC_W-1:8])) else $error("page changed");
  a_wdt_keeps_bank: assert property (wdt_pd_reset_in && !sys_reset_in && !wr |=> $stable(bank_select_out))
    else $error("bank lost on watchdog");
  a_sys_clears_bank: assert property (sys_reset_in |=> bank_select_out == 8'h00) else $error("bank kept");
  a_alu_to_acc: assert property (alu_load_acc_in && !sys_reset_in
    |=> accumulator_out == $past(alu_result_in)) else $error("acc not loaded");
  a_direct_ext_read: assert property (rd && mem_addr_in == 8'h12 |-> ext_sfr_rd_out)
    else $error("direct read missed");
  a_ext_only_read: assert property (ext_sfr_rd_out |-> rd) else $error("stray ext read");
  c_pcl_jump: cover property (program_counter_low);
  c_port_one_bank1: cover property (rd && mem_addr_in == 8'h02 && bank_select_out[0]);
  c_wdt_bank1: cover property (wdt_pd_reset_in && bank_select_out[0]);
endmodule
bind bdm_core bdm_core_monitor #(.PC_W(PC_W)) u_bdm_core_monitor (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .sys_reset_in(sys_reset_in), .wdt_pd_reset_in(wdt_pd_reset_in),
  .mem_req_in(mem_req_in), .mem_write_in(mem_write_in), .mem_addr_in(mem_addr_in),
  .mem_rdata_out(mem_rdata_out), .mem_rvalid_out(mem_rvalid_out), .alu_load_acc_in(alu_load_acc_in),
  .alu_result_in(alu_result_in), .accumulator_out(accumulator_out), .pc_out(pc_out),
  .dummy_cycle_out(dummy_cycle_out), .ext_sfr_rd_out(ext_sfr_rd_out), .bank_select_out(bank_select_out));
`default_nettype wire

/* test/bdm_sfr_model.sv */
// stand-in for the peripheral registers behind the external strobes
`timescale 1ns/1ps
`default_nettype none
module bdm_sfr_model (
  input  wire logic       clk_in,
  input  wire logic       ext_sfr_rd_out,
  input  wire logic [7:0] ext_sfr_addr_out,
  output logic [7:0]      ext_sfr_rdata_in
);
  logic [7:0] junk_q = 8'h5C;
  // idle bus changes every cycle so a stale sample cannot pass
  always @(posedge clk_in) junk_q <= junk_q + 8'h3B;
  // answer is a fixed function of the address, only while selected
  assign ext_sfr_rdata_in = ext_sfr_rd_out ? (ext_sfr_addr_out ^ 8'hA5) : junk_q;
endmodule
`default_nettype wire

/* test/bdm_core_tb.sv */
// self-checking bench for the data memory steering block
`timescale 1ns/1ps
`default_nettype none
module bdm_core_tb;
  import bdm_pkg::*;
  logic        clk_in, rst_n_in, sys_reset_in, wdt_pd_reset_in, mem_req_in, mem_write_in;
  logic        mem_wsrc_alu_in, alu_load_acc_in, pc_step_in, mem_rvalid_out, dummy_cycle_out;
  logic        ext_sfr_rd_out, ext_sfr_wr_out, eeprom_control_wr_out;
  logic [7:0]  mem_addr_in, alu_result_in, mem_rdata_out, accumulator_out, ext_sfr_addr_out;
  logic [7:0]  ext_sfr_wdata_out, ext_sfr_rdata_in, eeprom_control_register_out, bank_select_out;
  logic [11:0] pc_out;
  logic [7:0]  exp_q[$];
  logic [7:0]  r, p, e;
  logic [7:0]  holes[5] = '{8'h0C, 8'h1A, 8'h1D, 8'h20, 8'h5F};
  int          failures, check_count, seed, eewr_count;
  logic [15:0] ext_wr_seen;
  bdm_core u_bdm_core (.clk_in(clk_in), .rst_n_in(rst_n_in), .sys_reset_in(sys_reset_in),
    .wdt_pd_reset_in(wdt_pd_reset_in), .mem_req_in(mem_req_in), .mem_write_in(mem_write_in),
    .mem_addr_in(mem_addr_in), .mem_wsrc_alu_in(mem_wsrc_alu_in), .mem_rdata_out(mem_rdata_out),
    .mem_rvalid_out(mem_rvalid_out), .alu_load_acc_in(alu_load_acc_in), .alu_result_in(alu_result_in),
    .accumulator_out(accumulator_out), .pc_step_in(pc_step_in), .pc_out(pc_out),
    .dummy_cycle_out(dummy_cycle_out), .ext_sfr_rd_out(ext_sfr_rd_out), .ext_sfr_wr_out(ext_sfr_wr_out),
    .ext_sfr_addr_out(ext_sfr_addr_out), .ext_sfr_wdata_out(ext_sfr_wdata_out),
    .ext_sfr_rdata_in(ext_sfr_rdata_in), .eeprom_control_register_out(eeprom_control_register_out),
    .eeprom_control_wr_out(eeprom_control_wr_out), .bank_select_out(bank_select_out));
  bdm_sfr_model u_bdm_sfr_model (.clk_in(clk_in), .ext_sfr_rd_out(ext_sfr_rd_out),
    .ext_sfr_addr_out(ext_sfr_addr_out), .ext_sfr_rdata_in(ext_sfr_rdata_in));
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  // read data against the oldest note
  task automatic chk_rd(input logic [7:0] ex, input logic [7:0] got);
    check_count++;
    if (got !== ex) begin
      failures++;
      $display("ERROR %0t exp %h got %h", $time, ex, got);
    end
  endtask
  // register and strobe outputs against a fixed value
  task automatic chk_out(input logic [15:0] ex, input logic [15:0] got);
    check_count++;
    if (got !== ex) begin
      failures++;
      $display("ERROR %0t exp %h got %h", $time, ex, got);
    end
  endtask
  task automatic test_done();
    if (failures == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // one access per call; request stays up so calls run back to back
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_in);
    mem_req_in = 1'b1;
    mem_write_in = w;
    mem_addr_in = a;
    alu_result_in = d;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    acc(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] ex);
    acc(1'b0, a, 8'h00);
    exp_q.push_back(ex);
  endtask
  task automatic idle();
    @(negedge clk_in);
    mem_req_in = 1'b0;
  endtask
  // read answers are matched against the oldest note
  always @(negedge clk_in) begin
    if (mem_rvalid_out === 1'b1) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hXX;
      chk_rd(e, mem_rdata_out);
    end
  end
  // strobes are combinational, so take them at the edge that accepts them
  always @(posedge clk_in) begin
    if (ext_sfr_wr_out === 1'b1) ext_wr_seen <= {ext_sfr_addr_out, ext_sfr_wdata_out};
    if (eeprom_control_wr_out === 1'b1) eewr_count <= eewr_count + 1;
  end
  initial begin
    #100000;
    failures++;
    test_done();
  end
  initial begin
    {rst_n_in, sys_reset_in, wdt_pd_reset_in, mem_req_in, mem_write_in, alu_load_acc_in, pc_step_in} = 7'h00;
    mem_wsrc_alu_in = 1'b1;
    mem_addr_in = 8'h00;
    alu_result_in = 8'h00;
    seed = 66;
    r = 8'($random(seed));
    p = 8'h80 + {2'b00, r[5:0]};
    repeat (16) @(negedge clk_in);
    rst_n_in = 1'b1;
    chk_out(16'h0000, 16'(bank_select_out));
    wr(8'h01, r);
    rd(8'h01, r);
    wr(8'h03, ~r);
    rd(8'h03, ~r);
    // port zero ignores bank one
    wr(8'h04, 8'h01);
    wr(8'h01, p);
    wr(8'h00, ~r);
    rd(p, ~r);
    rd(8'h00, ~r);
    wr(8'h03, p);
    rd(8'h02, 8'h00);
    wr(8'h03, 8'h40);
    wr(8'h02, r);
    idle();
    chk_out(16'(r), 16'(eeprom_control_register_out));
    rd(8'h02, r);
    idle();
    alu_load_acc_in = 1'b1;
    alu_result_in = 8'hC3;
    wr(8'h03, 8'h05);
    alu_load_acc_in = 1'b0;
    rd(8'h02, 8'hC3);
    rd(8'h05, 8'hC3);
    // source select must stand through the whole write cycle
    mem_wsrc_alu_in = 1'b0;
    wr(8'hF0, 8'h00);
    rd(8'hF0, 8'hC3);
    mem_wsrc_alu_in = 1'b1;
    idle();
    // watchdog in power-down keeps the bank, others clear it
    wdt_pd_reset_in = 1'b1;
    @(negedge clk_in);
    wdt_pd_reset_in = 1'b0;
    chk_out(16'h0001, 16'(bank_select_out));
    sys_reset_in = 1'b1;
    @(negedge clk_in);
    sys_reset_in = 1'b0;
    chk_out(16'h0000, 16'(bank_select_out));
    // the pin reset clears a selected bank one as well
    wr(8'h04, 8'h01);
    idle();
    chk_out(16'h0001, 16'(bank_select_out));
    rst_n_in = 1'b0;
    @(negedge clk_in);
    rst_n_in = 1'b1;
    chk_out(16'h0000, 16'(bank_select_out));
    wr(8'h03, 8'h40);
    rd(8'h02, 8'h00);
    wr(8'h03, p);
    rd(8'h02, ~r);
    wr(8'h01, 8'h00);
    wr(8'h00, 8'h77);
    rd(8'h00, 8'h00);
    wr(8'h01, 8'h02);
    rd(8'h00, 8'h00);
    for (int i = 0; i < 5; i++) begin
      wr(holes[i], 8'hFF);
      rd(holes[i], 8'h00);
    end
    wr(8'hFF, r);
    rd(8'hFF, r);
    rd(8'h12, 8'h12 ^ 8'hA5);
    wr(8'h12, 8'h5A);
    idle();
    chk_out(16'h125A, ext_wr_seen);
    // move the counter into page one, then jump inside it
    pc_step_in = 1'b1;
    repeat (300) @(negedge clk_in);
    pc_step_in = 1'b0;
    chk_out(16'h012C, 16'(pc_out));
    wr(8'h06, 8'h34);
    idle();
    // a step offered during the dummy cycle is dropped
    pc_step_in = 1'b1;
    chk_out(16'h0134, 16'(pc_out));
    chk_out(16'h0001, 16'(dummy_cycle_out));
    @(negedge clk_in);
    pc_step_in = 1'b0;
    chk_out(16'h0134, 16'(pc_out));
    chk_out(16'h0000, 16'(dummy_cycle_out));
    chk_out(16'h0000, 16'(exp_q.size()));
    chk_out(16'h0001, 16'(eewr_count));
    test_done();
  end
endmodule
`default_nettype wire
